// *** design/line_coder_pkg.sv ***
// Shared constants and carrier types for the twisted-pair line coder.
package line_coder_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ      = 250; // Core clock rate.
    localparam int HALF_REF_MHZ = 20;  // Manchester half-bit reference.
    localparam int NIB_HALVES   = 8;   // Half-bit phases per 4-bit nibble.
    localparam int ACC_W        = 9;   // Width of the rate accumulator.
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(HALF_REF_MHZ);
    localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_MHZ);

    // ------------------------------------------------------------------
    // Widths, depths and reset values
    // ------------------------------------------------------------------
    localparam int NIB_W      = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [2:0] PHASE_RST = 3'h7;  // Next tick is a boundary.
    localparam logic [3:0] NIB_RST   = 4'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Line level: pos alone is +1, neg alone is -1, neither is 0.
    typedef struct packed {
        logic pos;
        logic neg;
    } line_lvl_s;

    localparam line_lvl_s LVL_ZERO  = '{pos: 1'b0, neg: 1'b0};
    localparam line_lvl_s LVL_PLUS  = '{pos: 1'b1, neg: 1'b0};
    localparam line_lvl_s LVL_MINUS = '{pos: 1'b0, neg: 1'b1};

    // Received nibble with its decode error flag.
    typedef struct packed {
        logic             err;
        logic [NIB_W-1:0] data;
    } rx_nib_s;

    // Three-level encoder states, one-hot.
    typedef enum logic [3:0] {
        MLT_ZERO_UP   = 4'h1,
        MLT_PLUS      = 4'h2,
        MLT_ZERO_DOWN = 4'h4,
        MLT_MINUS     = 4'h8
    } mlt_state_e;

endpackage

// *** design/phy_line_coder.sv ***
// Line coder: MLT-3 and Manchester paths with the MII nibble FIFO.
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Synchronous FIFO
// ----------------------------------------------------------------------
module nib_fifo
    import line_coder_pkg::*;
#(
    parameter int WIDTH = NIB_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             full_q, full_d, empty_q, empty_d;
    logic             push, pop;

    // Flags are registered so the ready and valid ports are flop outputs.
    assign push      = in_valid && !full_q;
    assign pop       = out_ready && !empty_q;
    assign in_ready  = !full_q;
    assign out_valid = !empty_q;
    assign out_data  = mem[rd_q];

    // Pointer and occupancy arithmetic.
    always_comb begin
        wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
        full_d  = (cnt_d == FULL_CNT);
        empty_d = (cnt_d == '0);
    end

    // Storage has no reset; only pointers, the occupancy count and flags need defined values.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q    <= '0;
            rd_q    <= '0;
            cnt_q   <= '0;
            full_q  <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            cnt_q   <= cnt_d;
            full_q  <= full_d;
            empty_q <= empty_d;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Line coder top
// ----------------------------------------------------------------------
module phy_line_coder
    import line_coder_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // Mode: high selects 100 Mb/s, low selects 10 Mb/s
    input  wire logic             mode_100,
    // 100M transmit bit stream
    input  wire logic             tx100_valid,
    input  wire logic             tx100_bit,
    // 100M receive bit streams
    input  wire logic             rx100_valid,
    output logic                  rx100_out_valid,
    output logic                  rx100_nrzi,
    output logic                  rx100_bit,
    // 10M MII transmit nibbles
    input  wire logic             tx_nib_valid,
    input  wire logic [NIB_W-1:0] tx_nib_data,
    output logic                  tx_nib_ready,
    // 10M MII receive nibbles and nibble clock
    output logic                  nibble_clk,
    output logic                  rx_nib_valid,
    output logic [NIB_W-1:0]      rx_nib_data,
    output logic                  rx_nib_err,
    // 10M recovered receive timing
    input  wire logic             rx10_frame,
    input  wire logic             rx10_half_valid,
    input  wire logic             rx10_half_first,
    // Twisted-pair line
    output logic                  line_tx_pos,
    output logic                  line_tx_neg,
    input  wire logic             line_rx_pos,
    input  wire logic             line_rx_neg
);
    // ------------------------------------------------------------------
    // Half-bit tick and nibble clock
    // ------------------------------------------------------------------
    logic [ACC_W-1:0] acc_q, acc_d;
    logic [2:0]       ph_q, ph_d;
    logic             tick, nclk_q, nclk_d;
    logic [ACC_W:0]   acc_sum;

    // The core rate is not a multiple of 20 MHz, so a fractional
    // accumulator is used; half-bits jitter by one core cycle.
    assign acc_sum = (ACC_W+1)'(acc_q) + (ACC_W+1)'(ACC_STEP);
    assign tick    = (acc_sum >= (ACC_W+1)'(ACC_WRAP));

    always_comb begin
        acc_d  = tick ? ACC_W'(acc_sum - (ACC_W+1)'(ACC_WRAP))
                      : ACC_W'(acc_sum);
        ph_d   = tick ? 3'(ph_q + 1'b1) : ph_q;
        nclk_d = ph_d[2];
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q  <= '0;
            ph_q   <= PHASE_RST;
            nclk_q <= 1'b1;
        end else begin
            acc_q  <= acc_d;
            ph_q   <= ph_d;
            nclk_q <= nclk_d;
        end
    end

    // ------------------------------------------------------------------
    // 10M transmit: FIFO and Manchester serializer
    // ------------------------------------------------------------------
    logic             fifo_valid, pop, busy_q, busy_d;
    logic [NIB_W-1:0] fifo_data, sh_q, sh_d;
    logic             man_bit, man_lvl;

    // A nibble is taken only at a nibble boundary in 10M mode, so the
    // MAC sees back-pressure while the line drains.
    assign pop = tick && (ph_q == PHASE_RST) && !mode_100;

    nib_fifo #(
        .WIDTH (NIB_W),
        .DEPTH (DEPTH)
    ) u_tx_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (tx_nib_valid),
        .in_data   (tx_nib_data),
        .in_ready  (tx_nib_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (pop)
    );

    always_comb begin
        busy_d = busy_q;
        sh_d   = sh_q;
        if (pop) begin
            busy_d = fifo_valid;
            sh_d   = fifo_valid ? fifo_data : NIB_RST;
        end else if (mode_100) begin
            busy_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            sh_q   <= NIB_RST;
        end else begin
            busy_q <= busy_d;
            sh_q   <= sh_d;
        end
    end

    // Bit index is the upper phase bits, so bit 0 goes out first.
    assign man_bit = sh_q[ph_q[2:1]];
    // First half carries the bit, second half its inverse.
    assign man_lvl = ph_q[0] ? !man_bit : man_bit;

    // ------------------------------------------------------------------
    // 100M transmit: three-level encoder
    // ------------------------------------------------------------------
    mlt_state_e mlt_q, mlt_d;
    line_lvl_s  mlt_lvl, tx_lvl_d;

    always_comb begin
        mlt_d = mlt_q;
        if (tx100_valid && tx100_bit && mode_100) begin
            case (mlt_q)
                MLT_ZERO_UP:   mlt_d = MLT_PLUS;
                MLT_PLUS:      mlt_d = MLT_ZERO_DOWN;
                MLT_ZERO_DOWN: mlt_d = MLT_MINUS;
                MLT_MINUS:     mlt_d = MLT_ZERO_UP;
                default:       mlt_d = MLT_ZERO_UP;
            endcase
        end
        case (mlt_d)
            MLT_PLUS:  mlt_lvl = LVL_PLUS;
            MLT_MINUS: mlt_lvl = LVL_MINUS;
            default:   mlt_lvl = LVL_ZERO;
        endcase
    end

    // One pair, two formats; an idle 10M line rests at zero.
    always_comb begin
        if (mode_100) begin
            tx_lvl_d = mlt_lvl;
        end else if (busy_q) begin
            tx_lvl_d = man_lvl ? LVL_PLUS : LVL_MINUS;
        end else begin
            tx_lvl_d = LVL_ZERO;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mlt_q       <= MLT_ZERO_UP;
            line_tx_pos <= 1'b0;
            line_tx_neg <= 1'b0;
        end else begin
            mlt_q       <= mlt_d;
            line_tx_pos <= tx_lvl_d.pos;
            line_tx_neg <= tx_lvl_d.neg;
        end
    end

    // ------------------------------------------------------------------
    // 100M receive: three-level and NRZI decoding
    // ------------------------------------------------------------------
    line_lvl_s rx_lvl, prev_q, prev_d;
    logic      nrzi_d, bit_d, oval_d;

    // Both wires high is not a legal level and is read as zero.
    assign rx_lvl = (line_rx_pos == line_rx_neg) ? LVL_ZERO
                  : line_lvl_s'{pos: line_rx_pos, neg: line_rx_neg};

    always_comb begin
        prev_d = prev_q;
        nrzi_d = rx100_nrzi;
        bit_d  = rx100_bit;
        oval_d = 1'b0;
        if (rx100_valid && mode_100) begin
            prev_d = rx_lvl;
            // A level change toggles the NRZI level.
            nrzi_d = rx100_nrzi ^ (rx_lvl != prev_q);
            // An NRZI transition decodes to a one.
            bit_d  = nrzi_d ^ rx100_nrzi;
            oval_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_q          <= LVL_ZERO;
            rx100_nrzi      <= 1'b0;
            rx100_bit       <= 1'b0;
            rx100_out_valid <= 1'b0;
        end else begin
            prev_q          <= prev_d;
            rx100_nrzi      <= nrzi_d;
            rx100_bit       <= bit_d;
            rx100_out_valid <= oval_d;
        end
    end

    // ------------------------------------------------------------------
    // 10M receive: Manchester decoder and nibble assembly
    // ------------------------------------------------------------------
    logic             first_q, first_d, got_q, got_d, bad_q, bad_d;
    logic [1:0]       cnt_q, cnt_d;
    logic [NIB_W-1:0] asm_q, asm_d;
    rx_nib_s          nib_q, nib_d;
    logic             nval_d;

    // Timing of half-bits comes from recovery outside this block; a
    // halves pair with equal levels is flagged, not dropped.
    always_comb begin
        first_d = first_q;
        got_d   = got_q;
        bad_d   = bad_q;
        cnt_d   = cnt_q;
        asm_d   = asm_q;
        nib_d   = nib_q;
        nval_d  = 1'b0;
        if (!rx10_frame || mode_100) begin
            got_d = 1'b0;
            bad_d = 1'b0;
            cnt_d = '0;
        end else if (rx10_half_valid && rx10_half_first) begin
            first_d = line_rx_pos;
            got_d   = 1'b1;
        end else if (rx10_half_valid && got_q) begin
            got_d = 1'b0;
            // High first half is a one.
            asm_d = {first_q, asm_q[NIB_W-1:1]};
            bad_d = bad_q || (first_q == line_rx_pos);
            cnt_d = 2'(cnt_q + 1'b1);
            if (cnt_q == 2'h3) begin
                nib_d  = '{err: bad_d, data: asm_d};
                nval_d = 1'b1;
                bad_d  = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_q      <= 1'b0;
            got_q        <= 1'b0;
            bad_q        <= 1'b0;
            cnt_q        <= '0;
            asm_q        <= NIB_RST;
            nib_q        <= '0;
            rx_nib_valid <= 1'b0;
        end else begin
            first_q      <= first_d;
            got_q        <= got_d;
            bad_q        <= bad_d;
            cnt_q        <= cnt_d;
            asm_q        <= asm_d;
            nib_q        <= nib_d;
            rx_nib_valid <= nval_d;
        end
    end

    assign rx_nib_data = nib_q.data;
    assign rx_nib_err  = nib_q.err;
    assign nibble_clk  = nclk_q;
endmodule

// *** tb/line_coder_props.sv ***
// Checker for the line coder ports.
`timescale 1ns/1ps
module line_coder_props
    import line_coder_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock, reset and mode
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic mode_100,
    // 100M streams
    input wire logic tx100_valid,
    input wire logic tx100_bit,
    input wire logic rx100_valid,
    input wire logic rx100_out_valid,
    input wire logic rx100_nrzi,
    input wire logic rx100_bit,
    // Nibble clock and line
    input wire logic nibble_clk,
    input wire logic line_tx_pos,
    input wire logic line_tx_neg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic step;
    logic last_pos_q;
    assign step = mode_100 && tx100_valid && tx100_bit;
    // Sign of the last non-zero level, so the 0,+1,0,-1 cycle is checked.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) last_pos_q <= 1'b0;
        else if (line_tx_pos ^ line_tx_neg) last_pos_q <= line_tx_pos;
    end
    a_levels_legal: assert property (!(line_tx_pos && line_tx_neg))
        else $error("line drives both halves of the pair");
    a_mlt_hold: assert property ($past(mode_100) && mode_100 && !step
        |=> $stable({line_tx_pos, line_tx_neg}))
        else $error("three-level output moved without a one");
    a_mlt_step: assert property ($past(mode_100) && mode_100 && step
        |=> (line_tx_pos | line_tx_neg) != $past(line_tx_pos | line_tx_neg))
        else $error("three-level output did not step");
    a_mlt_order: assert property ($past(mode_100) && mode_100 && step
        && !line_tx_pos && !line_tx_neg |=> line_tx_pos == !last_pos_q)
        else $error("three-level sign did not alternate");
    a_rx100_pulse: assert property (rx100_valid && mode_100
        |=> rx100_out_valid)
        else $error("no 100M receive result");
    a_rx100_quiet: assert property (!(rx100_valid && mode_100)
        |=> !rx100_out_valid)
        else $error("spurious 100M receive result");
    a_rx100_bit: assert property (rx100_valid && mode_100
        |=> rx100_bit == (rx100_nrzi != $past(rx100_nrzi)))
        else $error("decoded bit disagrees with level change");
    a_nclk_hold: assert property ($changed(nibble_clk)
        |=> $stable(nibble_clk) [*8])
        else $error("nibble clock phase too short");
    c_step: cover property (step && !line_tx_pos && !line_tx_neg);
    c_rx_one: cover property (rx100_out_valid && rx100_bit);
    c_nclk: cover property ($rose(nibble_clk));
endmodule
bind phy_line_coder line_coder_props #(.DEPTH(DEPTH)) chk_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .mode_100(mode_100),
    .tx100_valid(tx100_valid), .tx100_bit(tx100_bit),
    .rx100_valid(rx100_valid), .rx100_out_valid(rx100_out_valid),
    .rx100_nrzi(rx100_nrzi), .rx100_bit(rx100_bit),
    .nibble_clk(nibble_clk), .line_tx_pos(line_tx_pos),
    .line_tx_neg(line_tx_neg)
);

// *** tb/line_far_end.sv ***
// Far end of the twisted pair: samples transmit, drives receive.
`timescale 1ns/1ps
module line_far_end
    import line_coder_pkg::*;
(
    // Clock and reset
    input  wire logic      core_clk,
    input  wire logic      sys_rst,
    // Pairs on the coder side
    input  wire logic      line_tx_pos,
    input  wire logic      line_tx_neg,
    output logic           line_rx_pos,
    output logic           line_rx_neg,
    // Bench side
    input  wire logic      rx_en,
    input  wire line_lvl_s rx_lvl,
    output logic           half_seen,
    output line_lvl_s      half_lvl
);
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] sum;
    logic [3:0]       age_q;
    logic             junk_q;
    assign sum = acc_q + ACC_STEP;
    // Mid-half sampling tolerates a few cycles of grid skew.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= '0;
            age_q <= 4'h0;
            junk_q <= 1'b0;
        end else begin
            junk_q <= !junk_q;
            acc_q <= (sum >= ACC_WRAP) ? sum - ACC_WRAP : sum;
            age_q <= (sum >= ACC_WRAP) ? 4'h0 : age_q + 4'h1;
        end
    end
    assign half_seen = (age_q == 4'h6);
    assign half_lvl = '{pos: line_tx_pos, neg: line_tx_neg};
    // A released pair toggles, so a stale level cannot pass.
    assign line_rx_pos = rx_en ? rx_lvl.pos : junk_q;
    assign line_rx_neg = rx_en ? rx_lvl.neg : !junk_q;
endmodule

// *** tb/phy_line_coder_test.sv ***
// Self-checking bench for the line coder.
`timescale 1ns/1ps
module phy_line_coder_test
    import line_coder_pkg::*;
;
    logic             core_clk, sys_rst, mode_100, tx100_valid, tx100_bit;
    logic             rx100_valid, rx100_out_valid, rx100_nrzi, rx100_bit;
    logic             tx_nib_valid, tx_nib_ready, nibble_clk, rx_nib_valid;
    logic [NIB_W-1:0] tx_nib_data, rx_nib_data, nib;
    logic             rx_nib_err, rx10_frame, rx10_half_valid;
    logic             rx10_half_first, line_tx_pos, line_tx_neg;
    logic             line_rx_pos, line_rx_neg, rx_en, half_seen, b, nz;
    line_lvl_s        rx_lvl, half_lvl, lv, e, pe;
    logic [1:0]       s;
    logic [31:0]      rnd;
    int               bad_count, check_count, cyc, last_rise, i, j, k;
    logic             collect, nclk_q;
    logic             halves[$];
    logic [4:0]       got[$], exp_q[$];
    logic [3:0]       sent[$];

    phy_line_coder #(.DEPTH(FIFO_DEPTH)) dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .mode_100(mode_100),
        .tx100_valid(tx100_valid), .tx100_bit(tx100_bit),
        .rx100_valid(rx100_valid), .rx100_out_valid(rx100_out_valid),
        .rx100_nrzi(rx100_nrzi), .rx100_bit(rx100_bit),
        .tx_nib_valid(tx_nib_valid), .tx_nib_data(tx_nib_data),
        .tx_nib_ready(tx_nib_ready), .nibble_clk(nibble_clk),
        .rx_nib_valid(rx_nib_valid), .rx_nib_data(rx_nib_data),
        .rx_nib_err(rx_nib_err), .rx10_frame(rx10_frame),
        .rx10_half_valid(rx10_half_valid), .rx10_half_first(rx10_half_first),
        .line_tx_pos(line_tx_pos), .line_tx_neg(line_tx_neg),
        .line_rx_pos(line_rx_pos), .line_rx_neg(line_rx_neg)
    );
    line_far_end far_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .line_tx_pos(line_tx_pos),
        .line_tx_neg(line_tx_neg), .line_rx_pos(line_rx_pos),
        .line_rx_neg(line_rx_neg), .rx_en(rx_en), .rx_lvl(rx_lvl),
        .half_seen(half_seen), .half_lvl(half_lvl)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] ex, got_v);
        check_count++;
        if (got_v !== ex) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, ex, got_v);
        end
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One Manchester half towards the receiver, with a gap after it.
    task automatic half(input logic lvl, input logic first);
        rx_en <= 1'b1;
        rx_lvl <= '{pos: lvl, neg: !lvl};
        rx10_half_valid <= 1'b1;
        rx10_half_first <= first;
        @(posedge core_clk);
        rx10_half_valid <= 1'b0;
        @(posedge core_clk);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Monitors; the cycle ceiling is far above the few thousand needed.
    always @(posedge core_clk) begin
        cyc++;
        nclk_q <= nibble_clk;
        if (collect && half_seen && (half_lvl.pos | half_lvl.neg))
            halves.push_back(half_lvl.pos);
        if (rx_nib_valid) got.push_back({rx_nib_err, rx_nib_data});
        if (nibble_clk && !nclk_q && !sys_rst) begin
            if (last_rise > 0) chk("nclk period", 8'h64, 8'(cyc - last_rise));
            last_rise = cyc;
        end
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        {sys_rst, rx_en, collect, s, nz} = 6'h20;
        {mode_100, tx100_valid, tx100_bit, rx100_valid} = 4'h0;
        {tx_nib_valid, tx_nib_data, rx10_frame} = 6'h0;
        {rx10_half_valid, rx10_half_first, rx_lvl, pe} = 6'h0;
        rnd = 32'h303241d7;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        mode_100 <= 1'b1;
        repeat (2) @(posedge core_clk);
        for (i = 0; i < 64; i++) begin
            rnd = lfsr(rnd);
            b = (i < 6) | rnd[0];
            tx100_valid <= 1'b1;
            tx100_bit <= b;
            @(posedge core_clk);
            tx100_valid <= 1'b0;
            s = s + {1'b0, b};
            @(negedge core_clk);
            chk("mlt level", {s == 2'h1, s == 2'h3}, {line_tx_pos, line_tx_neg});
            @(posedge core_clk);
        end
        $display("Test mlt3 transmit done");
        for (i = 0; i < 48; i++) begin
            rnd = lfsr(rnd);
            lv = line_lvl_s'(rnd[1:0]);
            e = lv ^ {2{lv.pos & lv.neg}};
            rx_en <= 1'b1;
            rx_lvl <= lv;
            rx100_valid <= 1'b1;
            @(posedge core_clk);
            rx100_valid <= 1'b0;
            @(negedge core_clk);
            nz = nz ^ (e != pe);
            chk("rx100", {1'b1, nz, e != pe}, {rx100_out_valid, rx100_nrzi, rx100_bit});
            pe = e;
            @(posedge core_clk);
        end
        $display("Test mlt3 receive done");
        for (i = 0; i < 17; i++) begin
            rnd = lfsr(rnd);
            nib = (i == 0) ? 4'h1 : rnd[3:0];
            tx_nib_valid <= 1'b1;
            tx_nib_data <= nib;
            @(negedge core_clk);
            chk("fifo ready", 8'(i < 16), 8'(tx_nib_ready));
            if (tx_nib_ready) sent.push_back(nib);
            @(posedge core_clk);
        end
        tx_nib_valid <= 1'b0;
        mode_100 <= 1'b0;
        repeat (3) @(posedge core_clk);
        collect = 1'b1;
        for (i = 0; i < 3000 && halves.size() < 128; i++) @(posedge core_clk);
        for (k = 0; k < 16 && halves.size() >= 128; k++) begin
            for (j = 0; j < 4; j++) begin
                chk("half pair", 8'h1, 8'(halves[8*k+2*j] ^ halves[8*k+2*j+1]));
                nib[j] = halves[8*k+2*j];
            end
            chk("tx10 nibble", 8'(sent[k]), 8'(nib));
        end
        chk("tx10 halves", 8'h80, 8'(halves.size()));
        $display("Test manchester transmit done");
        rx10_frame <= 1'b1;
        half(1'b1, 1'b0);
        for (k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            for (j = 0; j < 4; j++) begin
                half(rnd[j], 1'b1);
                half(rnd[j] ^ !(k == 2 && j == 1), 1'b0);
            end
            exp_q.push_back({k == 2, rnd[3:0]});
        end
        repeat (4) @(posedge core_clk);
        chk("rx nibbles", 8'h4, 8'(got.size()));
        for (k = 0; k < 4 && k < got.size(); k++)
            chk("rx nibble", 8'(exp_q[k]), 8'(got[k]));
        $display("Test manchester receive done");
        results();
    end
endmodule
